// ===== rate_timing_defs.svh
/*
  Constants for the output rate and serial output timing register pair.
  Assumes it is included by bare name from the design file.
*/
`ifndef RATE_TIMING_DEFS_SVH
`define RATE_TIMING_DEFS_SVH

`define TIMING_ADDR 7'h04
`define RATE_ADDR 7'h02
`define TIMING_RESET 8'h9F
`define RATE_RESET 8'h00
`define EDGE_BIT 7
`define MODE_ZERO_A 4'hF
`define MODE_ZERO_B 4'hE
`define MODE_TEST_HI 4'hC
`define MODE_TEST_LO 4'hA
`define NOCLK_HI 4'hE
`define NOCLK_LO 4'hA
`define RATE_FULL 4'h0
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define ADDR_LAST 5'h07
`define DATA_FIRST 5'h08
`define FRAME_LAST 5'h0F
`define FRAME_END 5'h10

`endif

// ===== rate_timing_pkg.sv
/*
  Types shared by the register pair: SPI pin bundle and rate register layout.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rate_timing_pkg;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } spi_in_t;

  typedef struct packed {
    logic [3:0] out_mode;
    logic [3:0] clk_rate;
  } rate_reg_t;

endpackage

// ===== output_rate_and_sdo_timing_regs.sv
/*
  SPI-reached register pair: output data / clock rate control and serial
  output timing. Assumes SPI pins are asynchronous to clk and that clk runs
  well above four times the serial clock, since pins are oversampled.
*/
// Notes on behaviour
// - Upper nibble 1111/1110 forces data to zero
// - Test codes 1100-1010 undefined; host avoids them
// - Lower nibble acts only with independent enable
// - Lower codes 1110-1010 turn clock output off
// - Edge select: one falling, zero rising launch
`timescale 1ns/100ps
`include "rate_timing_defs.svh"

module output_rate_and_sdo_timing_regs
  import rate_timing_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic independent_rate_clock_enable,
  input wire logic [DATA_W-1:0] adc_data,
  output logic sdo,
  output logic sdo_oe,
  output logic [DATA_W-1:0] out_data,
  output logic data_clock_output_pair_en,
  output logic [3:0] clk_rate_sel,
  output logic serial_out_edge_select
);

  // Data path must be wide enough for at least one byte lane
  if (DATA_W < 8 || DATA_W > 32)
  begin : g_bad_width
    $error("DATA_W out of range");
  end

  function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Reset release through two flops
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Pin synchroniser; s1 is read only by s2, s3 keeps edge history
  spi_in_t s1_q, s2_q, s3_q, pin_in;
  assign pin_in = '{sclk: sclk, cs_n: cs_n, sdi: sdi};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      s2_q <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      s3_q <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic rise, fall, sel;
  assign rise = s2_q.sclk & ~s3_q.sclk;
  assign fall = ~s2_q.sclk & s3_q.sclk;
  assign sel = ~s2_q.cs_n;

  // Serial engine and register state
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] shift_q, shift_d;
  logic rd_q, rd_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] tx_q, tx_d;
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  logic [7:0] timing_q, timing_d;
  rate_reg_t rate_q, rate_d;

  always_comb
  begin
    cnt_d = cnt_q;
    shift_d = shift_q;
    rd_d = rd_q;
    addr_d = addr_q;
    tx_d = tx_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    timing_d = timing_q;
    rate_d = rate_q;
    if (!sel)
    begin
      cnt_d = `CNT_ZERO;
      oe_d = 1'b0;
    end
    else
    begin
      // Shift in on rising edges; extra bits past the frame are ignored
      if (rise && cnt_q < `FRAME_END)
      begin
        shift_d = {shift_q[14:0], s2_q.sdi};
        cnt_d = cnt_q + `CNT_ONE;
        if (cnt_q == `ADDR_LAST)
        begin
          rd_d = shift_d[7];
          addr_d = shift_d[6:0];
          oe_d = shift_d[7];
          // Read data snapshot taken once the address is known
          if (shift_d[6:0] == `TIMING_ADDR)
            tx_d = timing_q;
          else if (shift_d[6:0] == `RATE_ADDR)
            tx_d = rate_q;
          else
            tx_d = 8'h00;
          // Rising-launch mode puts the first data bit out at once
          if (!timing_q[`EDGE_BIT])
          begin
            sdo_d = tx_d[7];
            tx_d = {tx_d[6:0], 1'b0};
          end
        end
        else if (cnt_q >= `DATA_FIRST && !timing_q[`EDGE_BIT] && cnt_q < `FRAME_LAST)
        begin
          sdo_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
        // Whole byte in before anything is stored
        if (cnt_q == `FRAME_LAST && !rd_q)
        begin
          if (addr_q == `TIMING_ADDR)
            timing_d = shift_d[7:0];
          else if (addr_q == `RATE_ADDR)
            rate_d = shift_d[7:0];
        end
      end
      // Falling-launch mode shifts out between the sampling edges
      if (fall && timing_q[`EDGE_BIT] && cnt_q >= `DATA_FIRST && cnt_q <= `FRAME_LAST)
      begin
        sdo_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= `CNT_ZERO;
      shift_q <= 16'h0000;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      timing_q <= `TIMING_RESET;
      rate_q <= `RATE_RESET;
    end
    else
    begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      timing_q <= timing_d;
      rate_q <= rate_d;
    end
  end

  // Output shaping; test codes simply pass data, their result is undefined
  logic [DATA_W-1:0] data_q, data_d;
  logic clk_en_q, clk_en_d;
  logic [3:0] rate_sel_q, rate_sel_d;
  always_comb
  begin
    data_d = adc_data;
    if (rate_q.out_mode == `MODE_ZERO_A || rate_q.out_mode == `MODE_ZERO_B)
      data_d = '0;
    clk_en_d = 1'b1;
    rate_sel_d = `RATE_FULL;
    if (independent_rate_clock_enable)
    begin
      rate_sel_d = rate_q.clk_rate;
      clk_en_d = !in_range(rate_q.clk_rate, `NOCLK_LO, `NOCLK_HI);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_q <= '0;
      clk_en_q <= 1'b1;
      rate_sel_q <= `RATE_FULL;
    end
    else
    begin
      data_q <= data_d;
      clk_en_q <= clk_en_d;
      rate_sel_q <= rate_sel_d;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = oe_q;
  assign out_data = data_q;
  assign data_clock_output_pair_en = clk_en_q;
  assign clk_rate_sel = rate_sel_q;
  assign serial_out_edge_select = timing_q[`EDGE_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  zero_data_a: assert property (
    (rate_q.out_mode == `MODE_ZERO_A || rate_q.out_mode == `MODE_ZERO_B) |=> out_data == '0)
    else $error("data not forced to zero");

  test_pass_a: assert property (
    in_range(rate_q.out_mode, `MODE_TEST_LO, `MODE_TEST_HI) |=> out_data == $past(adc_data))
    else $error("test code data path changed");

  ignore_low_a: assert property (
    !independent_rate_clock_enable |=> clk_rate_sel == `RATE_FULL && data_clock_output_pair_en)
    else $error("lower nibble acted without enable");

  clock_off_a: assert property (
    independent_rate_clock_enable && in_range(rate_q.clk_rate, `NOCLK_LO, `NOCLK_HI)
    |=> !data_clock_output_pair_en)
    else $error("clock pair still driven");

  fall_launch_a: assert property (
    $changed(sdo) && $past(timing_q[`EDGE_BIT]) |-> $past(fall))
    else $error("sdo moved off falling edge");

  rise_launch_a: assert property (
    $changed(sdo) && !$past(timing_q[`EDGE_BIT]) |-> $past(rise))
    else $error("sdo moved off rising edge");

  write_take_a: assert property (
    sel && rise && cnt_q == `FRAME_LAST && !rd_q && addr_q == `TIMING_ADDR
    |=> timing_q == {$past(shift_q[6:0]), $past(s2_q.sdi)})
    else $error("timing write not stored");

  early_hold_a: assert property (
    cnt_q < `FRAME_LAST |=> $stable(rate_q) || $past(!sel))
    else $error("rate changed before full byte");

endmodule

// ===== spi_host_model.sv
/*
  SPI host model that frames register accesses for the rate/timing pair.
  Assumes sclk idles low and each sclk phase lasts six clk cycles.
*/
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // Idle pins until the first frame
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Command byte then data byte, MSB first; sdo sampled late in its phase
  task automatic xfer(input logic [15:0] f, input logic fall, output logic [7:0] rd);
    rd = 8'h00;
    cs_n <= 1'b0;
    hold(6);
    for (int i = 15; i >= 0; i--)
    begin
      sdi <= f[i];
      hold(6);
      if (fall && i < 8)
        rd[i] = sdo;
      sclk <= 1'b1;
      hold(6);
      if (!fall && i > 0 && i < 9)
        rd[i-1] = sdo;
      sclk <= 1'b0;
    end
    hold(6);
    cs_n <= 1'b1;
    sdi <= ~sdi; // Released line must not keep its last bit
    hold(6);
  endtask
endmodule

// ===== output_rate_and_sdo_timing_regs_tb_top.sv
/*
  Bench for the rate control and serial output timing registers.
  Assumes spi_host_model drives the SPI pins of the block.
*/
`timescale 1ns/100ps
module output_rate_and_sdo_timing_regs_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b0;
  logic e;
  logic sclk, cs_n, sdi, sdo, sdo_oe, pair_en, edge_sel;
  logic [15:0] adc = 16'h0000;
  logic [15:0] dout, d;
  logic [3:0] sel, up;
  logic [7:0] rd;
  int u;
  int error_cnt = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  output_rate_and_sdo_timing_regs dut (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .independent_rate_clock_enable(en), .adc_data(adc),
    .sdo(sdo), .sdo_oe(sdo_oe), .out_data(dout), .data_clock_output_pair_en(pair_en),
    .clk_rate_sel(sel), .serial_out_edge_select(edge_sel));
  spi_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected reg at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected port at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Zero forcing only for the two all-zero codes
  function automatic logic [15:0] exp_data(input logic [3:0] m, input logic [15:0] x);
    return (m == 4'hF || m == 4'hE) ? 16'h0000 : x;
  endfunction

  function automatic logic clk_on(input logic g, input logic [3:0] lo);
    return !(g && lo >= 4'hA && lo <= 4'hE);
  endfunction

  // Reset values, edge select, unmapped read, then rate code sweep
  initial
  begin
    void'($urandom(63));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    // Output enable must stand through the data byte of a read
    fork
      host.xfer(16'h8400, 1'b1, rd);
      begin
        repeat (150) @(posedge clk);
        chk_port(16'(sdo_oe), 16'h0001);
      end
    join
    chk_reg(rd, 8'h9F);
    chk_port(16'(sdo_oe), 16'h0000);
    chk_port(16'(edge_sel), 16'h0001);
    host.xfer(16'h8200, 1'b1, rd);
    chk_reg(rd, 8'h00);
    host.xfer(16'h9000, 1'b1, rd);
    chk_reg(rd, 8'h00);
    host.xfer(16'h041F, 1'b1, rd);
    chk_port(16'(edge_sel), 16'h0000);
    host.xfer(16'h8400, 1'b0, rd);
    chk_reg(rd, 8'h1F);
    host.xfer(16'h049F, 1'b0, rd);
    // Unmapped write must leave the timing register alone
    host.xfer(16'h1000, 1'b1, rd);
    host.xfer(16'h8400, 1'b1, rd);
    chk_reg(rd, 8'h9F);
    for (int i = 0; i < 16; i++)
    begin
      u = $urandom_range(0, 12);
      up = (i == 0) ? 4'hF : (i == 1) ? 4'hE : 4'(u > 9 ? u + 3 : u);
      e = i[0] ^ (i > 11); // Both enable levels over the no-clock codes
      d = 16'($urandom());
      host.xfer({8'h02, up, 4'(i)}, 1'b1, rd);
      adc <= d;
      en <= e;
      repeat (3) @(posedge clk);
      chk_port(dout, exp_data(up, d));
      chk_port(16'(clk_on(e, 4'(i))) ^ 16'(pair_en) ^ 16'(clk_on(e, 4'(i))),
        16'(clk_on(e, 4'(i))));
      chk_port(16'(sel), e ? 16'(i) : 16'h0000);
      host.xfer(16'h8200, 1'b1, rd);
      chk_reg(rd, {up, 4'(i)});
    end
    conclude();
  end

  // Watchdog well beyond the roughly 85 us the frames need
  initial
  begin
    #500us;
    error_cnt++;
    conclude();
  end
endmodule
